// ---- rtl/qsa_pkg.sv ----
// qsa_pkg: constants and carrier types of the quad channel serial audio output port
//
// Contract
// - sum select 01: ch1+ch2 sent on first output, ch3+ch4 on second output.
// - sum select 10: all four channels combined, sent on first output only.
// - stereo: ch1/ch2 on first output, ch3/ch4 on second, shared clocks.
// - port is clock master or slave; stereo or tdm; i2s, lj and rj formats.
// - tdm uses first output by default; pin select bit moves it to second.
// - tdm slot width, data width, slot map and output pin are programmable.
// - tdm frames of 2, 4, 8 or 16 slots; channels only in assigned slots.
// - unassigned tdm slots leave the active data output undriven.
// - master drives bit and frame clock; slave takes both from outside.
// - frame clock 50% duty in nonpulse mode, pulse at least one bit clock.
// - path works per sample, for nominal rates 32 kHz to 192 kHz.
// - per channel 10-bit gain compensation scales the word up to full scale.
// - per channel dc offset calibration removes systematic dc offset.
// - first order high-pass, 1.4 Hz at 48 kHz, cutoff scales with rate.
// - slot size code 00 gives 32, 01 gives 24, 10 gives 16 bit clocks.
// - master bit clock never above 24.576 MHz.
`default_nettype none
package qsa_pkg;
	localparam int NCH = 4;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] SUM_PAIR = 2'h1;
	localparam logic [1:0] SUM_ALL = 2'h2;
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_RJ = 2'h2;
	localparam logic [1:0] SLOT_24 = 2'h1;
	localparam logic [1:0] SLOT_16 = 2'h2;
	localparam logic [5:0] SLOTW_32 = 6'h20;
	localparam logic [5:0] SLOTW_24 = 6'h18;
	localparam logic [5:0] SLOTW_16 = 6'h10;
	localparam logic [5:0] DW_24 = 6'h18;
	localparam logic [5:0] DW_16 = 6'h10;
	localparam logic [4:0] MSB_IDX = 5'h17;
	localparam logic signed [27:0] SMP_MAX = 28'sh07fffff;
	localparam logic signed [27:0] SMP_MIN = 28'shf800000;
	localparam int CLK_KHZ = 100000;
	localparam int BCLK_MAX_KHZ = 24576;
	localparam int BCLK_HALF_MIN_I = (CLK_KHZ + 2 * BCLK_MAX_KHZ - 1) / (2 * BCLK_MAX_KHZ);
	localparam logic [7:0] BCLK_HALF_MIN = 8'(BCLK_HALF_MIN_I);
	localparam real HPF_FC_HZ = 1.4;
	localparam real HPF_FS_HZ = 48000.0;
	localparam real HPF_SCALE = 16777216.0;
	localparam logic [12:0] HPF_COEF = 13'(int'(2.0 * 3.14159265 * HPF_FC_HZ / HPF_FS_HZ * HPF_SCALE));
	typedef logic signed [23:0] qsa_smp_t;
	typedef struct packed {
		qsa_smp_t [3:0] ch;
	} qsa_frame_t;
	typedef struct packed {
		logic enable;
		logic master;
		logic tdm;
		logic pulse;
		logic [1:0] fmt;
		logic [1:0] slot_size;
		logic [1:0] tdm_slots;
		logic data16;
		logic tdm_output_pin_select;
		logic [1:0] channel_sum_select;
		logic hpf_en;
		logic [7:0] bclk_half;
		logic [3:0][3:0] slot_map;
	} qsa_cfg_t;
	typedef struct packed {
		logic [3:0][9:0] gain;
		qsa_smp_t [3:0] offset;
	} qsa_cal_t;
endpackage
`default_nettype wire

// ---- rtl/qsa_port.sv ----
// qsa_port: channel processing, frame fifo and serial audio output engine
`default_nettype none
module qsa_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = qsa_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire logic push = in_valid && in_ready;
	wire logic pop = out_valid && out_ready;
	wire logic [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem_r[rd_r];
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != (AW+1)'(DEPTH);
			out_valid <= cnt_nxt != '0;
		end
	end
endmodule

module qsa_port (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration and calibration
	input wire qsa_pkg::qsa_cfg_t cfg,
	input wire qsa_pkg::qsa_cal_t cal,
	// converter samples
	input wire logic smp_valid,
	output logic smp_ready,
	input wire qsa_pkg::qsa_frame_t smp_in,
	// bit clock pin
	input wire logic bclk_i,
	output logic bclk_o,
	output logic bclk_oe,
	// frame clock pin
	input wire logic lrclk_i,
	output logic lrclk_o,
	output logic lrclk_oe,
	// serial data pins
	output logic serial_out_first,
	output logic serial_out_first_oe,
	output logic serial_out_second,
	output logic serial_out_second_oe
);
	function automatic qsa_pkg::qsa_smp_t sat(input logic signed [27:0] v);
		if (v > qsa_pkg::SMP_MAX) begin
			return qsa_pkg::SMP_MAX[23:0];
		end
		if (v < qsa_pkg::SMP_MIN) begin
			return qsa_pkg::SMP_MIN[23:0];
		end
		return v[23:0];
	endfunction

	// ************************************************************
	// processing pipeline: offset, gain, high-pass, summing
	// ************************************************************
	qsa_pkg::qsa_frame_t ofs_r;
	qsa_pkg::qsa_frame_t gain_r;
	qsa_pkg::qsa_frame_t hpf_r;
	qsa_pkg::qsa_frame_t sum_r;
	qsa_pkg::qsa_frame_t sum_d;
	logic [3:0] vld_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	qsa_pkg::qsa_frame_t fifo_out;
	logic fstart;
	wire logic adv = fifo_in_ready;
	assign smp_ready = fifo_in_ready;

	for (genvar k = 0; k < qsa_pkg::NCH; k++) begin : g_ch
		logic signed [47:0] dc_r;
		wire logic signed [27:0] ofs_d = 28'($signed(smp_in.ch[k])) - 28'($signed(cal.offset[k]));
		wire logic signed [35:0] prod = $signed(ofs_r.ch[k]) * $signed({2'b01, cal.gain[k]});
		wire logic signed [27:0] gain_d = 28'($signed(prod[35:10]));
		// dc tracker with per sample coefficient
		wire logic signed [27:0] diff = 28'($signed(gain_r.ch[k])) - 28'($signed(dc_r[47:24]));
		wire logic signed [41:0] inc = $signed(diff[24:0]) * $signed({1'b0, qsa_pkg::HPF_COEF});
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				dc_r <= '0;
			end else if (adv && vld_r[1] && cfg.hpf_en) begin
				dc_r <= dc_r + 48'(inc);
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				ofs_r.ch[k] <= '0;
				gain_r.ch[k] <= '0;
				hpf_r.ch[k] <= '0;
			end else if (adv) begin
				ofs_r.ch[k] <= sat(ofs_d);
				gain_r.ch[k] <= sat(gain_d);
				hpf_r.ch[k] <= cfg.hpf_en ? sat(diff) : gain_r.ch[k];
			end
		end
	end

	wire logic signed [27:0] s12 = 28'($signed(hpf_r.ch[0])) + 28'($signed(hpf_r.ch[1]));
	wire logic signed [27:0] s34 = 28'($signed(hpf_r.ch[2])) + 28'($signed(hpf_r.ch[3]));
	wire qsa_pkg::qsa_smp_t pair12 = sat(s12);
	wire qsa_pkg::qsa_smp_t pair34 = sat(s34);
	wire qsa_pkg::qsa_smp_t all4 = sat(s12 + s34);
	// pair sums, four channel sum, pass through
	assign sum_d.ch = (cfg.channel_sum_select == qsa_pkg::SUM_PAIR) ? {pair34, pair34, pair12, pair12} :
		(cfg.channel_sum_select == qsa_pkg::SUM_ALL) ? {24'h0, 24'h0, all4, all4} : hpf_r.ch;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vld_r <= 4'h0;
			sum_r <= '0;
		end else if (adv) begin
			vld_r <= {vld_r[2:0], smp_valid};
			sum_r <= sum_d;
		end
	end

	qsa_fifo #(
		.WIDTH($bits(qsa_pkg::qsa_frame_t)),
		.DEPTH(qsa_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(vld_r[3]),
		.in_ready(fifo_in_ready),
		.in_data(sum_r),
		.out_valid(fifo_out_valid),
		.out_ready(fstart),
		.out_data(fifo_out)
	);

	// ************************************************************
	// clock pins: sampling in slave mode, generation in master mode
	// ************************************************************
	logic [2:0] bsy_r;
	logic [2:0] lsy_r;
	logic bst_r;
	logic lst_r;
	logic bprev_r;
	logic lprev_r;
	logic [7:0] dcnt_r;
	logic [9:0] mpos_r;
	// clamp the half period to keep the bit clock in range
	wire logic [7:0] half = (cfg.bclk_half < qsa_pkg::BCLK_HALF_MIN) ? qsa_pkg::BCLK_HALF_MIN : cfg.bclk_half;
	wire logic [5:0] slotw = (cfg.slot_size == qsa_pkg::SLOT_24) ? qsa_pkg::SLOTW_24 :
		(cfg.slot_size == qsa_pkg::SLOT_16) ? qsa_pkg::SLOTW_16 : qsa_pkg::SLOTW_32;
	// 2, 4, 8 or 16 slots
	wire logic [2:0] nsh = cfg.tdm ? 3'(cfg.tdm_slots) + 3'h1 : 3'h1;
	wire logic [4:0] nslots = 5'h1 << nsh;
	wire logic [9:0] flen = {4'h0, slotw} << nsh;
	wire logic left_lvl = cfg.tdm || (cfg.fmt != qsa_pkg::FMT_I2S);
	wire logic run_m = cfg.enable && cfg.master;
	wire logic m_fall = run_m && bclk_o && (dcnt_r == half - 8'h1);
	wire logic [9:0] mpos_nxt = (mpos_r >= flen - 10'h1) ? 10'h0 : mpos_r + 10'h1;
	// one bit clock pulse or half frame level
	wire logic mlr_nxt = (cfg.tdm && cfg.pulse) ? (mpos_nxt == 10'h0) :
		((mpos_nxt < (flen >> 1)) ? left_lvl : !left_lvl);
	wire logic bclk_st = cfg.master ? bclk_o : bst_r;
	wire logic lr_st = cfg.master ? lrclk_o : lst_r;
	wire logic fall = cfg.enable && bprev_r && !bclk_st;
	assign fstart = fall && (lr_st == left_lvl) && (lprev_r != left_lvl);
	wire logic rstart = fall && !cfg.tdm && (lr_st != left_lvl) && (lprev_r == left_lvl);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bsy_r <= 3'h0;
			lsy_r <= 3'h0;
			bst_r <= 1'b0;
			lst_r <= 1'b0;
		end else begin
			bsy_r <= {bsy_r[1:0], bclk_i};
			lsy_r <= {lsy_r[1:0], lrclk_i};
			bst_r <= (bsy_r[1] == bsy_r[2]) ? bsy_r[2] : bst_r;
			lst_r <= (lsy_r[1] == lsy_r[2]) ? lsy_r[2] : lst_r;
		end
	end

	// clock pins are driven only in master mode
	always_ff @(posedge clk) begin
		if (sys_rst || !run_m) begin
			dcnt_r <= 8'h0;
			// first falling edge lands on frame position zero, so no runt first frame
			mpos_r <= flen - 10'h1;
			bclk_o <= 1'b0;
			lrclk_o <= 1'b0;
		end else if (dcnt_r == half - 8'h1) begin
			dcnt_r <= 8'h0;
			bclk_o <= !bclk_o;
			if (m_fall) begin
				mpos_r <= mpos_nxt;
				lrclk_o <= mlr_nxt;
			end
		end else begin
			dcnt_r <= dcnt_r + 8'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bclk_oe <= 1'b0;
			lrclk_oe <= 1'b0;
			bprev_r <= 1'b0;
			lprev_r <= 1'b0;
		end else begin
			bclk_oe <= run_m;
			lrclk_oe <= run_m;
			bprev_r <= bclk_st;
			lprev_r <= fall ? lr_st : lprev_r;
		end
	end

	// ************************************************************
	// frame position and serial data
	// ************************************************************
	logic [5:0] bit_r;
	logic [4:0] slot_r;
	logic sync_r;
	qsa_pkg::qsa_frame_t frm_r;
	wire logic slot_end = bit_r == slotw - 6'h1;
	wire logic [5:0] bit_nxt = (fstart || rstart || slot_end) ? 6'h0 : bit_r + 6'h1;
	wire logic [4:0] slot_inc = slot_r + 5'(slot_r != 5'h1f);
	wire logic [4:0] slot_nxt = fstart ? 5'h0 : rstart ? 5'h1 : slot_end ? slot_inc : slot_r;
	wire qsa_pkg::qsa_frame_t fifo_frm = fifo_out_valid ? fifo_out : '0;
	wire qsa_pkg::qsa_frame_t cur = fstart ? fifo_frm : frm_r;
	wire logic [5:0] dw = cfg.data16 ? qsa_pkg::DW_16 : qsa_pkg::DW_24;
	wire logic [5:0] rj_off = (slotw > dw) ? slotw - dw : 6'h0;
	// i2s one bit delay, rj aligned to slot end, lj at slot start
	wire logic [5:0] off = (cfg.fmt == qsa_pkg::FMT_I2S) ? 6'h1 : (cfg.fmt == qsa_pkg::FMT_RJ) ? rj_off : 6'h0;
	wire logic [6:0] rel = {1'b0, bit_nxt} - {1'b0, off};
	wire logic in_rng = !rel[6] && (rel[5:0] < dw) && (slot_nxt < nslots);
	wire logic [4:0] idx = qsa_pkg::MSB_IDX - rel[4:0];
	// pair per pin in stereo mode
	wire qsa_pkg::qsa_smp_t st1 = (slot_nxt == 5'h0) ? cur.ch[0] : cur.ch[1];
	wire qsa_pkg::qsa_smp_t st2 = (slot_nxt == 5'h0) ? cur.ch[2] : cur.ch[3];
	logic [3:0] hit;
	for (genvar k = 0; k < qsa_pkg::NCH; k++) begin : g_hit
		// channel only in its assigned slot
		assign hit[k] = (slot_nxt == {1'b0, cfg.slot_map[k]}) && (slot_nxt < nslots);
	end
	wire qsa_pkg::qsa_smp_t tsmp = hit[0] ? cur.ch[0] : hit[1] ? cur.ch[1] : hit[2] ? cur.ch[2] : cur.ch[3];
	wire logic t_bit = in_rng && tsmp[idx];
	wire logic any_hit = |hit;
	wire logic sel2 = cfg.tdm_output_pin_select;
	wire logic d1 = cfg.tdm ? (!sel2 && t_bit) : (in_rng && st1[idx]);
	wire logic d2 = cfg.tdm ? (sel2 && t_bit) : (in_rng && st2[idx]);
	// release the line outside assigned slots
	wire logic oe1 = (sync_r || fstart) && (!cfg.tdm || (!sel2 && any_hit));
	wire logic oe2 = (sync_r || fstart) && (!cfg.tdm || (sel2 && any_hit));

	always_ff @(posedge clk) begin
		if (sys_rst || !cfg.enable) begin
			bit_r <= 6'h0;
			slot_r <= 5'h0;
			sync_r <= 1'b0;
			frm_r <= '0;
		end else if (fall) begin
			bit_r <= bit_nxt;
			slot_r <= slot_nxt;
			sync_r <= sync_r || fstart;
			frm_r <= cur;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !cfg.enable) begin
			serial_out_first <= 1'b0;
			serial_out_second <= 1'b0;
			serial_out_first_oe <= 1'b0;
			serial_out_second_oe <= 1'b0;
		end else if (fall) begin
			serial_out_first <= d1;
			serial_out_second <= d2;
			serial_out_first_oe <= oe1;
			serial_out_second_oe <= oe2;
		end
	end
endmodule
`default_nettype wire

// ---- sim/qsa_port_props.sv ----
// qsa_port_props: pin timing checks of the serial port
`default_nettype none
module qsa_port_props (
	// clock, reset, config
	input wire logic clk,
	input wire logic sys_rst,
	input wire qsa_pkg::qsa_cfg_t cfg,
	// pins
	input wire logic bclk_o,
	input wire logic bclk_oe,
	input wire logic lrclk_o,
	input wire logic lrclk_oe,
	input wire logic serial_out_first,
	input wire logic serial_out_first_oe,
	input wire logic serial_out_second,
	input wire logic serial_out_second_oe
);
	logic [15:0] run_r;
	logic [15:0] run_nxt;
	wire [7:0] hp = (cfg.bclk_half < 8'h03) ? 8'h03 : cfg.bclk_half;
	wire [15:0] sw = (cfg.slot_size == 2'h1) ? 16'h18 : (cfg.slot_size == 2'h2) ? 16'h10 : 16'h20;
	wire [15:0] lr_exp = (cfg.tdm ? 16'h1 : sw) * {7'h0, hp, 1'b0};
	// cycles the frame clock has stood high
	assign run_nxt = lrclk_o ? run_r + 16'h1 : 16'h0;
	always_ff @(posedge clk) begin
		run_r <= sys_rst ? 16'h0 : run_nxt;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_oe; 1 |=> bclk_oe == $past(cfg.enable && cfg.master) && lrclk_oe == bclk_oe; endproperty
	a_oe: assert property (p_oe) else $error("clock enable wrong");
	property p_slv; !cfg.master |-> !bclk_o && !lrclk_o && !bclk_oe; endproperty
	a_slv: assert property (p_slv) else $error("slave drives clocks");
	property p_hi; $rose(bclk_o) |=> bclk_o [*2]; endproperty
	a_hi: assert property (p_hi) else $error("bit clock high too short");
	property p_lo; $fell(bclk_o) |=> !bclk_o [*2]; endproperty
	a_lo: assert property (p_lo) else $error("bit clock low too short");
	property p_lr; $fell(lrclk_o) && cfg.master && (!cfg.tdm || cfg.pulse) |-> run_r == lr_exp; endproperty
	a_lr: assert property (p_lr) else $error("frame clock width wrong");
	property p_pa; cfg.tdm && !cfg.tdm_output_pin_select |-> !serial_out_second_oe; endproperty
	a_pa: assert property (p_pa) else $error("second pin driven");
	property p_pb; cfg.tdm && cfg.tdm_output_pin_select |-> !serial_out_first_oe; endproperty
	a_pb: assert property (p_pb) else $error("first pin driven");
	property p_dat; cfg.master && $changed(serial_out_first) |-> !bclk_o; endproperty
	a_dat: assert property (p_dat) else $error("data moved on high clock");
	property p_all; !cfg.tdm && cfg.channel_sum_select == 2'h2 |-> !serial_out_second; endproperty
	a_all: assert property (p_all) else $error("second pin not zero");
	c_pulse: cover property (cfg.pulse && $fell(lrclk_o));
	c_tdm2: cover property (cfg.tdm && serial_out_second_oe);
	c_pair: cover property (cfg.channel_sum_select == 2'h1 && serial_out_second);
endmodule
bind qsa_port qsa_port_props u_props (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .bclk_o(bclk_o),
	.bclk_oe(bclk_oe), .lrclk_o(lrclk_o), .lrclk_oe(lrclk_oe), .serial_out_first(serial_out_first),
	.serial_out_first_oe(serial_out_first_oe), .serial_out_second(serial_out_second),
	.serial_out_second_oe(serial_out_second_oe));
`default_nettype wire

// ---- sim/qsa_rx_model.sv ----
// qsa_rx_model: receiving host, slave clock source and frame capture
`default_nettype none
module qsa_rx_model (
	// setup
	input wire logic master,
	input wire logic slave_run,
	input wire logic left_lvl,
	input wire logic [8:0] half_bits,
	// clock pins
	input wire logic bclk_m,
	input wire logic lrclk_m,
	output logic bclk_s,
	output logic lrclk_s,
	// data pins
	input wire logic d1,
	input wire logic oe1,
	input wire logic d2,
	input wire logic oe2
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [511:0] cur1, cur2, cz1, cz2, last1, last2, lz1, lz2;
	int idx = 0;
	int flen = 0;
	int frames = 0;
	int pos = 0;
	logic lr_q = 1'b0;
	wire bc = master ? bclk_m : bclk_s;
	wire lr = master ? lrclk_m : lrclk_s;
	initial begin
		bclk_s = 1'b0;
		lrclk_s = 1'b0;
		#3;
		forever begin
			#62.5;
			if (!slave_run) begin
				bclk_s = 1'b0;
				lrclk_s = ~left_lvl;
				pos = 0;
			end else if (bclk_s) begin
				bclk_s = 1'b0;
				lrclk_s = (pos < half_bits) ? left_lvl : ~left_lvl;
				pos = (pos + 1) % (2 * half_bits);
			end else begin
				bclk_s = 1'b1;
			end
		end
	end
	// sample on bit clock rise; undriven line is pulled low
	always @(posedge bc) begin
		if (lr == left_lvl && lr_q != left_lvl) begin
			last1 = cur1;
			last2 = cur2;
			lz1 = cz1;
			lz2 = cz2;
			flen = idx;
			idx = 0;
			frames++;
		end
		if (idx < 512) begin
			cur1[idx] = oe1 & d1;
			cz1[idx] = oe1;
			cur2[idx] = oe2 & d2;
			cz2[idx] = oe2;
		end
		idx++;
		lr_q = lr;
	end
endmodule
`default_nettype wire

// ---- sim/test_qsa_port.sv ----
// test_qsa_port: directed scenarios of the serial audio output port
`default_nettype none
module test_qsa_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	qsa_pkg::qsa_cfg_t cfg = '0;
	qsa_pkg::qsa_cal_t cal = '0;
	logic smp_valid = 1'b0;
	qsa_pkg::qsa_frame_t smp_in = {24'h400000, 24'h300000, 24'h200000, 24'h100000};
	logic slave_run = 1'b0;
	logic left_lvl = 1'b1;
	logic [8:0] half_bits = 9'h040;
	logic smp_ready, bclk_o, bclk_oe, lrclk_o, lrclk_oe, so1, so1_oe, so2, so2_oe, bclk_s, lrclk_s;
	logic [23:0] v [4] = '{24'h100000, 24'h200000, 24'h300000, 24'h400000};
	int errors = 0;
	int checks_done = 0;
	initial forever #5 clk = ~clk;
	qsa_port u_dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .cal(cal), .smp_valid(smp_valid),
		.smp_ready(smp_ready), .smp_in(smp_in), .bclk_i(bclk_s), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
		.lrclk_i(lrclk_s), .lrclk_o(lrclk_o), .lrclk_oe(lrclk_oe), .serial_out_first(so1),
		.serial_out_first_oe(so1_oe), .serial_out_second(so2), .serial_out_second_oe(so2_oe));
	qsa_rx_model u_rx (.master(cfg.master), .slave_run(slave_run), .left_lvl(left_lvl),
		.half_bits(half_bits), .bclk_m(bclk_o), .lrclk_m(lrclk_o), .bclk_s(bclk_s), .lrclk_s(lrclk_s),
		.d1(so1), .oe1(so1_oe), .d2(so2), .oe2(so2_oe));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [23:0] word(input logic [511:0] b, input int at, input int n);
		logic [23:0] r;
		r = '0;
		for (int i = 0; i < n; i++) r = {r[22:0], b[at + i]};
		return r;
	endfunction
	function automatic qsa_pkg::qsa_cfg_t base();
		qsa_pkg::qsa_cfg_t c;
		c = '0;
		c.enable = 1'b1;
		c.master = 1'b1;
		c.fmt = 2'h1;
		c.bclk_half = 8'h04;
		return c;
	endfunction
	// reset with the new setup, then offer samples
	task automatic start(input qsa_pkg::qsa_cfg_t c);
		sys_rst <= 1'b1;
		smp_valid <= 1'b0;
		cfg <= c;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		smp_valid <= 1'b1;
	endtask
	task automatic frames(input int n);
		int f;
		f = u_rx.frames;
		for (int i = 0; i < 40000 && u_rx.frames < f + n; i++) @(posedge clk);
		if (u_rx.frames < f + n) chk(u_rx.frames, f + n);
	endtask
	task automatic chk4(input int off, input logic [23:0] e [4]);
		for (int k = 0; k < 4; k++) chk(word(k < 2 ? u_rx.last1 : u_rx.last2, off + (k % 2) * 32, 24), e[k]);
	endtask
	task automatic t_stereo_fifo();
		qsa_pkg::qsa_cfg_t c;
		c = base();
		c.fmt = qsa_pkg::FMT_I2S;
		left_lvl <= 1'b0;
		start(c);
		for (int i = 0; i < 20 && smp_ready !== 1'b1; i++) @(posedge clk);
		for (int i = 0; i < 300 && smp_ready !== 1'b0; i++) @(posedge clk);
		chk(smp_ready, 1'b0);
		smp_valid <= 1'b0;
		frames(16);
		chk(word(u_rx.last1, 1, 24), 24'h0);
		smp_valid <= 1'b1;
		frames(4);
		chk4(1, v);
		chk(u_rx.flen, 64);
	endtask
	task automatic t_sum();
		qsa_pkg::qsa_cfg_t c;
		logic [23:0] e [4];
		for (int m = 0; m < 4; m++) begin
			c = base();
			c.channel_sum_select = 2'(m);
			if (m == 3) c.fmt = qsa_pkg::FMT_RJ;
			left_lvl <= 1'b1;
			start(c);
			frames(5);
			e = v;
			if (m == 1) e = '{24'h300000, 24'h300000, 24'h700000, 24'h700000};
			if (m == 2) e = '{24'h7fffff, 24'h7fffff, 24'h0, 24'h0};
			chk4((m == 3) ? 8 : 0, e);
		end
	endtask
	task automatic t_tdm_slave();
		qsa_pkg::qsa_cfg_t c;
		c = base();
		c.master = 1'b0;
		c.tdm = 1'b1;
		c.fmt = qsa_pkg::FMT_RJ;
		c.slot_size = qsa_pkg::SLOT_16;
		c.tdm_slots = 2'h2;
		c.data16 = 1'b1;
		c.tdm_output_pin_select = 1'b1;
		c.slot_map = {4'h6, 4'h4, 4'h3, 4'h1};
		slave_run <= 1'b1;
		start(c);
		frames(5);
		for (int s = 0; s < 8; s++) chk(u_rx.lz2[s * 16 +: 16], (s inside {1, 3, 4, 6}) ? 16'hffff : 16'h0);
		for (int k = 0; k < 4; k++) chk(word(u_rx.last2, c.slot_map[k] * 16, 16), v[k][23:8]);
		chk(u_rx.lz1[127:0], 0);
		chk(u_rx.flen, 128);
		slave_run <= 1'b0;
	endtask
	task automatic t_tdm_pulse();
		qsa_pkg::qsa_cfg_t c;
		c = base();
		c.tdm = 1'b1;
		c.pulse = 1'b1;
		c.slot_size = qsa_pkg::SLOT_24;
		c.tdm_slots = 2'h1;
		c.bclk_half = 8'h02;
		c.slot_map = {4'h3, 4'h2, 4'h1, 4'h0};
		start(c);
		frames(5);
		for (int k = 0; k < 4; k++) chk(word(u_rx.last1, k * 24, 24), v[k]);
		chk(u_rx.lz2[95:0], 0);
		chk(u_rx.flen, 96);
	endtask
	// offset and gain per channel, then the high-pass on a constant input
	task automatic t_cal();
		qsa_pkg::qsa_cfg_t c;
		logic [23:0] e [4];
		c = base();
		left_lvl <= 1'b1;
		cal.offset <= {24'hf00000, 24'h000000, 24'h000000, 24'h180000};
		cal.gain <= {10'h000, 10'h100, 10'h200, 10'h000};
		start(c);
		frames(5);
		e = '{24'hf80000, 24'h300000, 24'h3c0000, 24'h500000};
		chk4(0, e);
		cal <= '0;
		c.hpf_en = 1'b1;
		start(c);
		frames(8);
		chk(word(u_rx.last1, 0, 24) inside {[24'h0f0000 : 24'h0ffffe]}, 1'b1);
	endtask
	initial begin
		t_stereo_fifo();
		t_sum();
		t_cal();
		t_tdm_slave();
		t_tdm_pulse();
		final_report();
	end
	initial begin
		#1ms;
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
